// ---- rtl/nbc_buf2.sv ----
/*
  Two-entry valid/ready read buffer.
  Assumes one clock.
*/
`timescale 1ns/1ps
module nbc_buf2 #(
  parameter int W = 8
) (
  input  wire logic sys_clk_i,    // system clock
  input  wire logic nrst_i,       // async reset, low
  nbc_strm_if.dst   fill_if,      // producer side
  nbc_strm_if.src   drain_if      // consumer side
);
  typedef struct packed {
    logic [1:0]        v;
    logic [1:0][W-1:0] dat;
  } nbc_buf_t;

  nbc_buf_t q;
  nbc_buf_t d;
  logic     pop;
  logic     push;

  // ---------------------------------------------------------------
  // head at entry 0; a pop shifts entry 1 down before the push lands
  // ---------------------------------------------------------------
  assign fill_if.ready  = ~q.v[1];
  assign drain_if.valid = q.v[0];
  assign drain_if.data  = q.dat[0];
  assign pop            = q.v[0] & drain_if.ready;
  assign push           = fill_if.valid & ~q.v[1];

  always_comb begin
    d = q;
    if (pop) begin
      d.dat[0] = q.dat[1];
      d.v[0]   = q.v[1];
      d.v[1]   = 1'b0;
    end
    if (push) begin
      if (!d.v[0]) begin
        d.dat[0] = fill_if.data;
        d.v[0]   = 1'b1;
      end else begin
        d.dat[1] = fill_if.data;
        d.v[1]   = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- rtl/nbc_ctrl.sv ----
/*
  Host controller driving an 8-bit NAND flash over its pins.
  Assumes a pull-up on ready/busy and a pin wrapper for io_bus.
*/
`timescale 1ns/1ps
module nbc_ctrl
  import nbc_pkg::*;
(
  input  wire logic              sys_clk_i,       // 50 MHz clock
  input  wire logic              nrst_i,          // async reset, low
  input  wire logic              cmd_valid_i,     // operation request
  input  wire logic [3:0]        cmd_op_i,        // nbc_op_t code
  input  wire logic [ADDR_W-1:0] cmd_addr_i,      // row/column address
  input  wire logic [LEN_W-1:0]  cmd_len_i,       // byte count
  output logic                   cmd_ready_o,     // idle, request taken
  output logic                   done_o,          // operation finished
  input  wire logic              wr_valid_i,      // program byte valid
  input  wire logic [7:0]        wr_data_i,       // program byte
  output logic                   wr_ready_o,      // program byte taken
  output logic                   rd_valid_o,      // read byte valid
  output logic [7:0]             rd_data_o,       // read byte
  input  wire logic              rd_ready_i,      // read byte taken
  input  wire logic [7:0]        io_bus_i,        // bus level in
  output logic [7:0]             io_bus_o,        // bus drive value
  output logic                   io_bus_oe_o,     // bus driven, high
  output logic                   cle_o,           // command latch
  output logic                   ale_o,           // address latch
  output logic                   ce_n_o,          // chip select, low
  output logic                   we_n_o,          // write strobe, low
  output logic                   read_strobe_n_o, // read strobe, low
  output logic                   wp_n_o,          // write protect, low
  input  wire logic              rb_n_i           // ready high, busy low
);
  typedef enum logic [3:0] {
    S_IDLE, S_PRE, S_CMD1, S_ADDR, S_DIN, S_CMD2, S_GAP, S_RB, S_DOUT
  } nbc_st_t;

  typedef struct packed {
    nbc_st_t          st;
    nbc_op_t          op;
    logic [39:0]      addr;
    logic [LEN_W-1:0] len;
    logic [3:0]       ph;
    logic [2:0]       acnt;
    logic [7:0]       io;
    logic             io_oe;
    logic             cle;
    logic             ale;
    logic             ce_n;
    logic             we_n;
    logic             re_n;
    logic             wp_n;
    logic             cmd_rdy;
    logic             done;
    logic             wr_rdy;
    logic             have;
    logic             loaded;
    logic             push;
    logic [7:0]       pdata;
    logic [7:0]       io_s1;
    logic [7:0]       io_s2;
    logic             rb_s1;
    logic             rb_s2;
  } nbc_ctl_t;

  localparam nbc_ctl_t Q_RST = '{st: S_IDLE, op: OP_READ, ce_n: 1'b1,
    we_n: 1'b1, re_n: 1'b1, default: '0};

  nbc_ctl_t  q;
  nbc_ctl_t  d;
  nbc_desc_t dsc;
  logic      wlast;

  nbc_strm_if #(.W(8)) fill_if ();
  nbc_strm_if #(.W(8)) drain_if ();

  // ---------------------------------------------------------------
  // read path: only full-cycle samples enter the buffer
  // ---------------------------------------------------------------
  assign fill_if.valid  = q.push;
  assign fill_if.data   = q.pdata;
  assign drain_if.ready = rd_ready_i;

  nbc_buf2 #(.W(8)) u_buf (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .fill_if   (fill_if),
    .drain_if  (drain_if)
  );

  // outputs from flops
  assign cmd_ready_o     = q.cmd_rdy;
  assign done_o          = q.done;
  assign wr_ready_o      = q.wr_rdy;
  assign rd_valid_o      = drain_if.valid;
  assign rd_data_o       = drain_if.data;
  assign io_bus_o        = q.io;
  assign io_bus_oe_o     = q.io_oe;
  assign cle_o           = q.cle;
  assign ale_o           = q.ale;
  assign ce_n_o          = q.ce_n;
  assign we_n_o          = q.we_n;
  assign read_strobe_n_o = q.re_n;
  assign wp_n_o          = q.wp_n;

  assign dsc   = op_desc(q.op);
  assign wlast = (q.ph == WC_CYC);

  // ---------------------------------------------------------------
  // sequencer: write strobe low from ph 0, high at WP_CYC
  // ---------------------------------------------------------------
  always_comb begin
    d        = q;
    d.io_s1  = io_bus_i;
    d.io_s2  = q.io_s1;
    d.rb_s1  = rb_n_i;
    d.rb_s2  = q.rb_s1;
    d.done   = 1'b0;
    d.push   = 1'b0;
    d.wr_rdy = 1'b0;
    // shared write strobe
    if (q.st == S_CMD1 || q.st == S_ADDR || q.st == S_CMD2 ||
        (q.st == S_DIN && (q.have || q.ph != 4'h0))) begin
      d.io_oe = 1'b1;
      d.ph    = q.ph + 4'h1;
      if (q.ph == 4'h0) begin
        d.we_n = 1'b0;
      end
      if (q.ph == WP_CYC) begin
        d.we_n = 1'b1;                                 // RULE_01
      end
    end
    case (q.st)
      S_IDLE: begin
        d.ce_n = 1'b1;
        d.wp_n = 1'b0;                                 // RULE_08
        if (cmd_valid_i && q.cmd_rdy) begin
          d.op   = nbc_op_t'(cmd_op_i);
          d.addr = pack_addr(cmd_addr_i);              // RULE_10
          d.len  = cmd_len_i;
          d.st   = S_PRE;
        end
      end
      S_PRE: begin
        // a confirm without loaded data is dropped, never sent
        if ((dsc.need_load && !q.loaded) ||
            (!dsc.has_cmd1 && dsc.n_addr == 3'h0)) begin
          d.done = 1'b1;                               // RULE_25
          d.st   = S_IDLE;
        end else if (q.rb_s2 || dsc.busy_ok) begin     // RULE_11
          d.ce_n = 1'b0;
          d.wp_n = dsc.modify;                         // RULE_18
          d.ph   = 4'h0;
          d.acnt = 3'h0;
          if (dsc.fix_len != '0) begin
            d.len = dsc.fix_len;
          end
          if (q.op == OP_PROG) begin
            d.loaded = 1'b1;
          end else if (q.op == OP_PROG_GO || q.op == OP_RESET) begin
            d.loaded = 1'b0;
          end
          d.st = dsc.has_cmd1 ? S_CMD1 : S_ADDR;       // RULE_23
        end
      end
      S_CMD1, S_CMD2: begin
        d.cle = 1'b1;                                  // RULE_02
        d.io  = (q.st == S_CMD1) ? dsc.cmd1 : dsc.cmd2; // RULE_12
        if (wlast) begin
          d.ph = 4'h0;
          if (q.st == S_CMD1 && dsc.n_addr != 3'h0) begin
            d.st = S_ADDR;
          end else begin
            d.cle   = 1'b0;
            d.io_oe = 1'b0;
            d.st    = S_GAP;                           // RULE_26
          end
        end
      end
      S_ADDR: begin
        d.cle = 1'b0;
        d.ale = 1'b1;                                  // RULE_03
        d.io  = q.addr[{3'(q.acnt + dsc.a_first), 3'b000} +: 8];
        if (wlast) begin
          d.ph   = 4'h0;
          d.acnt = q.acnt + 3'h1;
          if (q.acnt + 3'h1 == dsc.n_addr) begin       // RULE_24
            d.ale = 1'b0;
            if (dsc.din) begin
              d.st = S_DIN;                            // RULE_15
            end else if (dsc.has_cmd2) begin
              d.st = S_CMD2;                           // RULE_13 RULE_14
            end else begin
              d.io_oe = 1'b0;
              d.st    = S_GAP;
            end
          end
        end
      end
      S_DIN: begin
        d.cle = 1'b0;                                  // RULE_19
        d.ale = 1'b0;
        if (q.len == '0) begin
          d.io_oe = 1'b0;
          d.done  = 1'b1;
          d.st    = S_IDLE;
        end else if (!q.have && q.ph == 4'h0) begin
          // ready held high until a byte is taken, then dropped, keeps a stalled source lossless
          d.wr_rdy = ~(q.wr_rdy & wr_valid_i);
          if (q.wr_rdy && wr_valid_i) begin
            d.io   = wr_data_i;
            d.have = 1'b1;
          end
        end else begin
          d.have = 1'b0;
          if (wlast) begin
            d.ph  = 4'h0;
            d.len = q.len - 12'h001;
          end
        end
      end
      S_GAP: begin
        // covers busy onset and strobe-to-read turnaround
        d.ph = q.ph + 4'h1;
        if (q.ph == GAP_CYC) begin
          d.ph = 4'h0;
          if (dsc.wait_rb) begin
            d.st = S_RB;
          end else if (dsc.dout) begin
            d.st = S_DOUT;
          end else begin
            d.done = 1'b1;
            d.st   = S_IDLE;
          end
        end
      end
      S_RB: begin
        if (q.rb_s2) begin                             // RULE_09 RULE_26
          if (dsc.dout) begin
            d.st = S_DOUT;
          end else begin
            d.done = 1'b1;
            d.st   = S_IDLE;
          end
        end
      end
      S_DOUT: begin
        // strobe held low until the synchronised bus is settled
        if (q.ph == 4'h0) begin
          if (q.len == '0) begin
            d.done = 1'b1;
            d.st   = S_IDLE;
          end else if (fill_if.ready) begin
            d.re_n = 1'b0;                             // RULE_06 RULE_20
            d.ph   = 4'h1;
          end
        end else begin
          d.ph = q.ph + 4'h1;
          if (q.ph == RDL_CYC) begin
            d.re_n  = 1'b1;
            d.push  = 1'b1;                            // RULE_17
            d.pdata = q.io_s2;
          end
          if (q.ph == RC_CYC) begin
            d.ph  = 4'h0;
            d.len = q.len - 12'h001;                   // RULE_16
          end
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    if (d.st == S_IDLE) begin
      d.ce_n  = 1'b1;
      d.wp_n  = 1'b0;
      d.io_oe = 1'b0;
      d.cle   = 1'b0;
      d.ale   = 1'b0;
      d.we_n  = 1'b1;
      d.re_n  = 1'b1;
      d.ph    = 4'h0;
      d.have  = 1'b0;
    end
    d.cmd_rdy = (d.st == S_IDLE) && !(q.st == S_IDLE && cmd_valid_i &&
                                      q.cmd_rdy);
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- rtl/nbc_pkg.sv ----
/*
  Constants, types and command tables for a host NAND flash controller.
  Assumes a 50 MHz clock.
*/
// Notes on behaviour
// RULE_01: io_bus latched on write-strobe rise.
// RULE_02: command latch loads the command register.
// RULE_03: address latch loads the next address byte.
// RULE_04: select changes while busy never abort.
// RULE_05: select may drop during a read.
// RULE_06: read-strobe fall gives a byte, column plus one.
// RULE_07: device floats io_bus when deselected.
// RULE_08: write protect low blocks program and erase.
// RULE_09: ready/busy is open drain, wired low.
// RULE_10: five address bytes, unused bits low.
// RULE_11: while busy only FFh and 70h are taken.
// RULE_12: read is 00h, five address bytes, 30h.
// RULE_13: program is 80h, address, data, 10h.
// RULE_14: erase is 60h, block address, D0h.
// RULE_15: 85h and column bytes move the input column.
// RULE_16: 05h, column bytes, E0h move the output column.
// RULE_17: 90h gives four signature bytes.
// RULE_18: write protect high through program/erase setup.
// RULE_19: data input: latches low, read strobe high.
// RULE_20: data output: latches low, write strobe high.
// RULE_21: page is 2048 main plus 64 spare bytes.
// RULE_22: 2048 blocks of 128 pages.
// RULE_23: read mode at power-up; repeat read may skip 00h.
// RULE_24: erase takes two block-address bytes.
// RULE_25: 10h without data input starts nothing.
// RULE_26: busy low from confirm until done.
package nbc_pkg;

  // -------------------------------------------------------------------
  // timing in ns and clock counts
  // -------------------------------------------------------------------
  localparam int CLK_NS    = 20;
  localparam int T_WP_NS   = 40;   // write strobe low
  localparam int T_WH_NS   = 20;   // write strobe high
  localparam int T_REA_NS  = 45;   // read strobe fall to data valid
  localparam int T_REH_NS  = 20;   // read strobe high
  localparam int T_WB_NS   = 100;  // strobe rise to busy
  localparam int T_WHR_NS  = 80;   // strobe rise to read strobe fall
  localparam int SYNC_STG  = 2;

  localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WH_CYC  = 4'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WC_CYC  = 4'(WP_CYC + WH_CYC);
  localparam logic [3:0] RDL_CYC =
    4'((T_REA_NS + CLK_NS - 1) / CLK_NS + SYNC_STG);
  localparam logic [3:0] RC_CYC  =
    4'(RDL_CYC + (T_REH_NS + CLK_NS - 1) / CLK_NS);
  localparam int WB_RAW  = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_RAW = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] GAP_CYC =
    4'(((WB_RAW > WHR_RAW) ? WB_RAW : WHR_RAW) + SYNC_STG);

  // -------------------------------------------------------------------
  // geometry and command codes
  // -------------------------------------------------------------------
  localparam int PAGE_MAIN  = 2048;             // RULE_21
  localparam int PAGE_SPARE = 64;
  localparam int PAGES_BLK  = 128;              // RULE_22
  localparam int BLOCKS     = 2048;
  localparam int ADDR_W     = 30;
  localparam int LEN_W      = 12;
  localparam logic [LEN_W-1:0] SIG_LEN  = 12'h004;
  localparam logic [LEN_W-1:0] STAT_LEN = 12'h001;
  localparam logic [2:0] ERASE_FIRST = 3'h2;    // RULE_24
  localparam logic [2:0] ERASE_CYCS  = 3'h2;

  localparam logic [7:0] CMD_READ     = 8'h00;
  localparam logic [7:0] CMD_READ_GO  = 8'h30;
  localparam logic [7:0] CMD_PROG     = 8'h80;
  localparam logic [7:0] CMD_PROG_GO  = 8'h10;
  localparam logic [7:0] CMD_ERASE    = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_RAND_IN  = 8'h85;
  localparam logic [7:0] CMD_RAND_OUT = 8'h05;
  localparam logic [7:0] CMD_RAND_GO  = 8'hE0;
  localparam logic [7:0] CMD_SIG      = 8'h90;
  localparam logic [7:0] CMD_STATUS   = 8'h70;
  localparam logic [7:0] CMD_RESET    = 8'hFF;

  typedef enum logic [3:0] {
    OP_READ, OP_READ_NEXT, OP_PROG, OP_RAND_IN, OP_PROG_GO,
    OP_ERASE, OP_RAND_OUT, OP_SIG, OP_STATUS, OP_RESET
  } nbc_op_t;

  typedef struct packed {
    logic             has_cmd1;
    logic [7:0]       cmd1;
    logic [2:0]       n_addr;
    logic [2:0]       a_first;
    logic             din;
    logic             has_cmd2;
    logic [7:0]       cmd2;
    logic             wait_rb;
    logic             dout;
    logic [LEN_W-1:0] fix_len;
    logic             modify;
    logic             busy_ok;
    logic             need_load;
  } nbc_desc_t;

  // -------------------------------------------------------------------
  // per-operation bus sequence
  // -------------------------------------------------------------------
  function automatic nbc_desc_t op_desc(input nbc_op_t op);
    nbc_desc_t r;
    r = '0;
    case (op)
      OP_READ:      r = '{1'b1, CMD_READ, 3'h5, 3'h0, 1'b0, 1'b1,
                          CMD_READ_GO, 1'b1, 1'b1, '0, 1'b0, 1'b0, 1'b0};
      OP_READ_NEXT: r = '{1'b0, CMD_READ, 3'h5, 3'h0, 1'b0, 1'b1,
                          CMD_READ_GO, 1'b1, 1'b1, '0, 1'b0, 1'b0, 1'b0};
      OP_PROG:      r = '{1'b1, CMD_PROG, 3'h5, 3'h0, 1'b1, 1'b0,
                          8'h00, 1'b0, 1'b0, '0, 1'b1, 1'b0, 1'b0};
      OP_RAND_IN:   r = '{1'b1, CMD_RAND_IN, 3'h2, 3'h0, 1'b1, 1'b0,
                          8'h00, 1'b0, 1'b0, '0, 1'b1, 1'b0, 1'b0};
      OP_PROG_GO:   r = '{1'b1, CMD_PROG_GO, 3'h0, 3'h0, 1'b0, 1'b0,
                          8'h00, 1'b1, 1'b0, '0, 1'b1, 1'b0, 1'b1};
      OP_ERASE:     r = '{1'b1, CMD_ERASE, ERASE_CYCS, ERASE_FIRST, 1'b0,
                          1'b1, CMD_ERASE_GO, 1'b1, 1'b0, '0, 1'b1,
                          1'b0, 1'b0};
      OP_RAND_OUT:  r = '{1'b1, CMD_RAND_OUT, 3'h2, 3'h0, 1'b0, 1'b1,
                          CMD_RAND_GO, 1'b0, 1'b1, '0, 1'b0, 1'b0, 1'b0};
      OP_SIG:       r = '{1'b1, CMD_SIG, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00,
                          1'b0, 1'b1, SIG_LEN, 1'b0, 1'b0, 1'b0};
      OP_STATUS:    r = '{1'b1, CMD_STATUS, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00,
                          1'b0, 1'b1, STAT_LEN, 1'b0, 1'b1, 1'b0};
      OP_RESET:     r = '{1'b1, CMD_RESET, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00,
                          1'b1, 1'b0, '0, 1'b0, 1'b1, 1'b0};
      default:      r = '0;
    endcase
    return r;
  endfunction

  // five address bytes, spare bits low
  function automatic logic [39:0] pack_addr(input logic [ADDR_W-1:0] a);
    return {6'h00, a[29:28], a[27:20], a[19:12], 4'h0, a[11:8], a[7:0]};
  endfunction

endpackage

// ---- rtl/nbc_strm_if.sv ----
/*
  Valid/ready byte stream.
  Assumes one clock.
*/
`timescale 1ns/1ps
interface nbc_strm_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// ---- test/nbc_ctrl_checker.sv ----
/*
  Port assertions for the flash controller.
  Assumes a bind to nbc_ctrl.
*/
`timescale 1ns/1ps
module nbc_ctrl_checker (
  input wire logic       sys_clk_i,       // system clock
  input wire logic       nrst_i,          // async reset, low
  input wire logic       cmd_valid_i,     // request valid
  input wire logic       cmd_ready_o,     // request taken
  input wire logic       done_o,          // op finished
  input wire logic [7:0] io_bus_o,        // bus drive value
  input wire logic       io_bus_oe_o,     // bus driven
  input wire logic       cle_o,           // command latch
  input wire logic       ale_o,           // address latch
  input wire logic       ce_n_o,          // chip select, low
  input wire logic       we_n_o,          // write strobe, low
  input wire logic       read_strobe_n_o, // read strobe, low
  input wire logic       wp_n_o,          // write protect, low
  input wire logic       rb_n_i           // ready high
);
  // -------------------------------------------------------------------
  // strobe shape and qualifiers
  // -------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  a_we_shape: assert property (
    $fell(we_n_o) |=> !we_n_o ##1 we_n_o) else $error("bad write strobe");
  a_we_hold: assert property (
    $fell(we_n_o) |=> ($stable(io_bus_o) && $stable(cle_o)
      && $stable(ale_o))[*2]) else $error("bus moved in write");
  a_re_shape: assert property (
    $fell(read_strobe_n_o) |-> !read_strobe_n_o[*5] ##1 read_strobe_n_o)
    else $error("bad read strobe");
  a_strobe_qual: assert property (
    !we_n_o |-> read_strobe_n_o && !ce_n_o) else $error("write unqualified");
  a_latch_excl: assert property (
    !(cle_o && ale_o)) else $error("both latches high");
  a_oe_read: assert property (
    !read_strobe_n_o |-> !io_bus_oe_o && !cle_o && !ale_o && we_n_o)
    else $error("drive in read");
  a_wp_modify: assert property (
    $rose(we_n_o) && cle_o && (io_bus_o == 8'h80 || io_bus_o == 8'h60
      || io_bus_o == 8'hD0 || io_bus_o == 8'h10) |-> wp_n_o)
    else $error("modify with protect");
  a_ce_busy: assert property (
    !ce_n_o && !rb_n_i |=> !ce_n_o) else $error("select dropped busy");
  a_done_once: assert property (
    done_o |-> ce_n_o ##1 !done_o) else $error("bad done pulse");
endmodule

bind nbc_ctrl nbc_ctrl_checker i_nbc_ctrl_checker (.sys_clk_i, .nrst_i,
  .cmd_valid_i, .cmd_ready_o, .done_o, .io_bus_o, .io_bus_oe_o, .cle_o,
  .ale_o, .ce_n_o, .we_n_o, .read_strobe_n_o, .wp_n_o, .rb_n_i);

// ---- test/nbc_nand_model.sv ----
/*
  Behavioural flash device on the controller pins.
  Assumes the bench resolves the bus.
*/
`timescale 1ns/1ps
module nbc_nand_model #(
  parameter int          T_BUSY_NS = 2000,         // shortened array time
  parameter logic [31:0] SIG       = 32'h5AC3_963C // arbitrary value
) (
  input  wire logic       cle_i,  // command latch
  input  wire logic       ale_i,  // address latch
  input  wire logic       ce_n_i, // chip select, low
  input  wire logic       we_n_i, // write strobe, low
  input  wire logic       re_n_i, // read strobe, low
  input  wire logic       wp_n_i, // write protect, low
  input  wire logic [7:0] bus_i,  // resolved bus
  output logic      [7:0] dq_o,   // device side of bus
  output logic            busy_o  // pulls ready line low
);
  logic [7:0]  mem [logic [29:0]];
  logic [7:0]  pb [2112];
  logic [39:0] ad = '0;
  logic [7:0]  dat = '0;
  logic        drv = 0;
  logic        ld = 0;
  int          na = 0;
  int          col = 0;
  int          md = 0;
  int          sx = 0;
  int          c;
  initial busy_o = 0;
  // released bus shows the inverse, so a stale byte never passes
  assign dq_o = drv ? dat : ~dat;

  // ---------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------
  task automatic take(input logic [7:0] b);
    logic [17:0] r;
    r = {ad[33:32], ad[31:16]};
    na = (b == 8'h60) ? 2 : 0;
    case (b)
      8'h00: md = 0;
      8'h30: begin
        for (c = 0; c < 2112; c++)
          pb[c] = mem.exists({r, 12'(c)}) ? mem[{r, 12'(c)}] : 8'hFF;
        busy();
      end
      8'h80: begin
        ld = 1;
        pb = '{default: 8'hFF};
      end
      8'h10: begin
        if (ld && wp_n_i) begin
          for (c = 0; c < 2112; c++) mem[{r, 12'(c)}] = pb[c];
          busy();
        end
        ld = 0;
      end
      8'hD0: if (wp_n_i) begin
        foreach (mem[k]) if (k[29:19] == r[17:7]) mem[k] = 8'hFF;
        busy();
      end
      8'h90: begin
        md = 1;
        sx = 0;
      end
      8'h70: md = 2;
      8'hFF: begin
        md = 0;
        ld = 0;
      end
      default: ; // col moves via address
    endcase
  endtask

  task automatic busy();
    fork
      begin
        busy_o = 1;
        #(T_BUSY_NS) busy_o = 0;
      end
    join_none
  endtask

  // latch on write strobe rise; select changes never abort
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (cle_i) begin
      if (!busy_o || bus_i == 8'hFF || bus_i == 8'h70) take(bus_i);
    end else if (ale_i) begin
      if (na < 5) ad[na*8 +: 8] = bus_i;
      na++;
      col = int'(ad[11:0]);
    end else if (ld) begin
      pb[col] = bus_i;
      col++;
    end
  end

  // byte out on read strobe fall
  always @(negedge re_n_i) begin
    #30;
    dat = md == 1 ? SIG[8*(3-sx) +: 8]
        : md == 2 ? {1'b1, !busy_o, 6'h00} : pb[col];
    drv = 1;
    if (md == 1) sx++;
    else if (md == 0) col++;
  end
  always @(posedge re_n_i or posedge ce_n_i) drv = 0;
endmodule

// ---- test/tb_nbc_ctrl.sv ----
/*
  Bench: controller against the flash model.
  Assumes one 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_nbc_ctrl;
  localparam logic [31:0] SIG = 32'h5AC3_963C; // arbitrary value
  logic        sys_clk_i = 0;
  logic        nrst_i = 0;
  logic        cmd_valid_i = 0;
  logic [3:0]  cmd_op_i = '0;
  logic [29:0] cmd_addr_i = '0;
  logic [11:0] cmd_len_i = '0;
  logic        wr_valid_i = 0;
  logic [7:0]  wr_data_i = '0;
  logic        rd_ready_i = 1;
  logic        stall = 0;
  logic [7:0]  io_bus_i, io_bus_o, rd_data_o, dq;
  logic        cmd_ready_o, done_o, wr_ready_o, rd_valid_o, io_bus_oe_o;
  logic        cle_o, ale_o, ce_n_o, we_n_o, read_strobe_n_o, wp_n_o;
  logic        busy, rb_n_i;
  logic [7:0]  wq[$], rq[$];
  int          n_fail = 0, num_checks = 0, cyc = 0, ce_falls = 0;

  // -------------------------------------------------------------------
  // pins, clock and streams
  // -------------------------------------------------------------------
  assign io_bus_i = io_bus_oe_o ? io_bus_o : dq;
  assign rb_n_i = !busy; // pull-up
  always #10 sys_clk_i = ~sys_clk_i;
  always @(negedge ce_n_o) ce_falls++;
  nbc_ctrl i_nbc_ctrl (.sys_clk_i, .nrst_i, .cmd_valid_i, .cmd_op_i,
    .cmd_addr_i, .cmd_len_i, .cmd_ready_o, .done_o, .wr_valid_i,
    .wr_data_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .rd_ready_i,
    .io_bus_i, .io_bus_o, .io_bus_oe_o, .cle_o, .ale_o, .ce_n_o, .we_n_o,
    .read_strobe_n_o, .wp_n_o, .rb_n_i);
  nbc_nand_model #(.SIG(SIG)) i_nbc_nand_model (.cle_i(cle_o),
    .ale_i(ale_o), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
    .re_n_i(read_strobe_n_o), .wp_n_i(wp_n_o), .bus_i(io_bus_i),
    .dq_o(dq), .busy_o(busy));
  // stalls long enough to fill the buffer
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (rd_valid_o && rd_ready_i) rq.push_back(rd_data_o);
    if (wr_valid_i && wr_ready_o) void'(wq.pop_front());
    #1 wr_valid_i = wq.size() > 0;
    wr_data_i = wq.size() > 0 ? wq[0] : 8'h00;
    rd_ready_i = !(stall && cyc[5]);
  end

  task automatic op(input logic [3:0] o, input logic [29:0] a,
                    input logic [11:0] n);
    int i;
    @(posedge sys_clk_i);
    #1 {cmd_op_i, cmd_addr_i, cmd_len_i, cmd_valid_i} = {o, a, n, 1'b1};
    do @(posedge sys_clk_i); while (cmd_ready_o !== 1'b1);
    #1 cmd_valid_i = 0;
    for (i = 0; i < 20000 && done_o !== 1'b1; i++) @(posedge sys_clk_i);
    if (i == 20000) chk("done", 8'h01, 8'h00);
    while (rd_valid_o !== 1'b0) @(posedge sys_clk_i);
  endtask

  task automatic chk(input string nm, input logic [7:0] e, s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rdchk(input string nm, input logic [7:0] e[$]);
    chk({nm, " count"}, 8'(e.size()), 8'(rq.size()));
    foreach (e[i]) chk(nm, e[i], rq[i]);
    rq.delete();
    $display("test %s ended", nm);
  endtask

  task automatic t_sig();
    op(4'd7, '0, '0);
    rdchk("sig", {SIG[31:24], SIG[23:16], SIG[15:8], SIG[7:0]});
  endtask

  // spare-area end, column jump, then stalled read
  task automatic t_prog_read();
    wq = {8'h11, 8'h22, 8'h33, 8'h44};
    op(4'd2, 30'h0008_1838, 12'h004);
    wq = {8'hA5, 8'h5A};
    op(4'd3, 30'h0008_183E, 12'h002);
    op(4'd4, '0, '0);
    stall = 1;
    op(4'd0, 30'h0008_1838, 12'h008);
    stall = 0;
    rdchk("page", {8'h11, 8'h22, 8'h33, 8'h44, 8'hFF, 8'hFF,
                   8'hA5, 8'h5A});
  endtask

  task automatic t_column();
    op(4'd6, 30'h0000_083E, 12'h002);
    rdchk("random out", {8'hA5, 8'h5A});
    op(4'd1, 30'h0008_1839, 12'h001);
    rdchk("repeat read", {8'h22});
  endtask

  // other page of the erased block
  task automatic t_erase();
    int f;
    op(4'd5, 30'h0008_0000, '0);
    op(4'd0, 30'h0008_1838, 12'h001);
    rdchk("erased", {8'hFF});
    f = ce_falls;
    op(4'd4, '0, '0);
    chk("lone confirm", 8'(f), 8'(ce_falls));
    op(4'd8, '0, '0);
    chk("ready bit", 8'h40, rq.size() > 0 ? rq[0] & 8'h40 : 8'h00);
    rq.delete();
    op(4'd9, '0, '0);
    op(4'hF, '0, '0);
    $display("test erase ended");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1 nrst_i = 1;
    t_sig();
    t_prog_read();
    t_column();
    t_erase();
    tally_and_finish();
  end
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule
